// [hsq_fifo_bank.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Functional notes
// - Four queues, each one byte store shared by all its typed data ports.
// - Fill through one port type, drain through another; byte order kept.
// - A read wanting more bytes than held answers with an error.
// - Capacity set in bytes; word ports move four bytes, half port two.
// - Occupancy rises by bytes written and falls by bytes read.
// - Any write to flush empties the queue; reading flush is an error.
// - Per-queue registers sit two addresses apart from each base.
module hsq_fifo_bank (
  // Clock, reset, enable
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  // Register request
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [15:0] req_addr_in,
  input wire logic [31:0] req_wdata_in,
  output logic req_ready_out,
  // Register answer
  output logic resp_valid_out,
  input wire logic resp_ready_in,
  output logic [31:0] resp_data_out,
  output logic resp_err_out
);
  import hsq_pkg::*;

  // ==========================================================
  // Helpers
  // Matches one register group at an even offset inside its span
  function automatic logic group_hit(input logic [15:0] addr, input logic [15:0] base);
    logic [15:0] off;
    off = addr - base;
    group_hit = (addr >= base) && (off < HSQ_SPAN) && (off[0] == 1'b0);
  endfunction

  // Bytes moved by a data port access
  function automatic logic [2:0] port_bytes(input hsq_kind_t k);
    port_bytes = (k == HSQ_K_HALF) ? HSQ_HALF_BYTES : HSQ_WORD_BYTES;
  endfunction

  // Flat byte address inside the shared store
  function automatic logic [7:0] mem_index(input logic [1:0] q, input logic [5:0] ptr,
                                           input logic [2:0] i);
    logic [5:0] p;
    p = ptr + {3'h0, i};
    mem_index = {q, p};
  endfunction

  // ==========================================================
  // State
  logic [HSQ_MEM_W-1:0] mem_q [0:HSQ_NQ*HSQ_DEPTH-1];
  logic [HSQ_PTR_W-1:0] wp_q [0:HSQ_NQ-1];
  logic [HSQ_PTR_W-1:0] rp_q [0:HSQ_NQ-1];
  logic [HSQ_CNT_W-1:0] cnt_q [0:HSQ_NQ-1];
  logic [HSQ_CNT_W-1:0] cap_q [0:HSQ_NQ-1];

  hsq_kind_t kind;
  logic [1:0] q;
  logic [15:0] qoff;
  logic [2:0] nb;
  logic is_data;
  logic fire;
  logic err;
  logic ok;
  logic [31:0] rdata;
  logic [7:0] rbyte [0:3];
  logic [7:0] wbyte [0:3];
  logic [7:0] fill_sum;

  // ==========================================================
  // Address decode
  always_comb begin
    kind = HSQ_K_NONE;
    qoff = 16'h0000;
    if (group_hit(req_addr_in, HSQ_ADDR_HALF)) begin
      kind = HSQ_K_HALF;
      qoff = req_addr_in - HSQ_ADDR_HALF;
    end else if (group_hit(req_addr_in, HSQ_ADDR_UWORD)) begin
      kind = HSQ_K_UWORD;
      qoff = req_addr_in - HSQ_ADDR_UWORD;
    end else if (group_hit(req_addr_in, HSQ_ADDR_SWORD)) begin
      kind = HSQ_K_SWORD;
      qoff = req_addr_in - HSQ_ADDR_SWORD;
    end else if (group_hit(req_addr_in, HSQ_ADDR_FLOAT)) begin
      kind = HSQ_K_FLOAT;
      qoff = req_addr_in - HSQ_ADDR_FLOAT;
    end else if (group_hit(req_addr_in, HSQ_ADDR_CAP)) begin
      kind = HSQ_K_CAP;
      qoff = req_addr_in - HSQ_ADDR_CAP;
    end else if (group_hit(req_addr_in, HSQ_ADDR_OCC)) begin
      kind = HSQ_K_OCC;
      qoff = req_addr_in - HSQ_ADDR_OCC;
    end else if (group_hit(req_addr_in, HSQ_ADDR_FLUSH)) begin
      kind = HSQ_K_FLUSH;
      qoff = req_addr_in - HSQ_ADDR_FLUSH;
    end
  end

  // Queue number from stride
  assign q = qoff[2:1];
  assign nb = port_bytes(kind);
  assign is_data = (kind == HSQ_K_HALF) || (kind == HSQ_K_UWORD) ||
                   (kind == HSQ_K_SWORD) || (kind == HSQ_K_FLOAT);
  assign fire = ce_in & req_valid_in & req_ready_out;
  assign fill_sum = {1'b0, cnt_q[q]} + {5'h00, nb};

  // Byte lanes, first byte in the most significant lane
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      rbyte[i] = mem_q[mem_index(q, rp_q[q], 3'(i))];
      wbyte[i] = 8'h00;
    end
    if (kind == HSQ_K_HALF) begin
      wbyte[0] = req_wdata_in[15:8];
      wbyte[1] = req_wdata_in[7:0];
    end else begin
      wbyte[0] = req_wdata_in[31:24];
      wbyte[1] = req_wdata_in[23:16];
      wbyte[2] = req_wdata_in[15:8];
      wbyte[3] = req_wdata_in[7:0];
    end
  end

  // Error and read data per register kind
  always_comb begin
    err = 1'b0;
    rdata = 32'h0000_0000;
    case (kind)
      HSQ_K_HALF, HSQ_K_UWORD, HSQ_K_SWORD, HSQ_K_FLOAT: begin
        if (req_write_in) begin
          err = (fill_sum > {1'b0, cap_q[q]});
        end else begin
          err = (cnt_q[q] < {4'h0, nb});
          if (kind == HSQ_K_HALF) begin
            rdata = {16'h0000, rbyte[0], rbyte[1]};
          end else begin
            rdata = {rbyte[0], rbyte[1], rbyte[2], rbyte[3]};
          end
        end
      end
      HSQ_K_CAP: begin
        if (req_write_in) begin
          err = (req_wdata_in > 32'(HSQ_DEPTH));
        end else begin
          rdata = {25'h0000000, cap_q[q]};
        end
      end
      HSQ_K_OCC: begin
        err = req_write_in;
        rdata = {25'h0000000, cnt_q[q]};
      end
      HSQ_K_FLUSH: begin
        err = ~req_write_in;
      end
      default: begin
        err = 1'b1;
      end
    endcase
    if (err) begin
      rdata = 32'h0000_0000;
    end
  end

  assign ok = fire & ~err;

  // ==========================================================
  // Byte store writes
  always_ff @(posedge clock_in) begin
    if (ok && is_data && req_write_in) begin
      for (int i = 0; i < 4; i++) begin
        if (3'(i) < nb) begin
          mem_q[mem_index(q, wp_q[q], 3'(i))] <= wbyte[i];
        end
      end
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int j = 0; j < HSQ_NQ; j++) begin
        wp_q[j] <= HSQ_PTR_RST;
        rp_q[j] <= HSQ_PTR_RST;
        cnt_q[j] <= HSQ_CNT_RST;
      end
    end else if (ok) begin
      if (is_data && req_write_in) begin
        wp_q[q] <= wp_q[q] + {3'h0, nb};
        cnt_q[q] <= fill_sum[HSQ_CNT_W-1:0];
      end else if (is_data) begin
        rp_q[q] <= rp_q[q] + {3'h0, nb};
        cnt_q[q] <= cnt_q[q] - {4'h0, nb};
      end else if (req_write_in && (kind == HSQ_K_FLUSH || kind == HSQ_K_CAP)) begin
        rp_q[q] <= wp_q[q];
        cnt_q[q] <= HSQ_CNT_RST;
      end
    end
  end

  // Capacity registers
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int j = 0; j < HSQ_NQ; j++) begin
        cap_q[j] <= HSQ_CAP_RST;
      end
    end else if (ok && req_write_in && kind == HSQ_K_CAP) begin
      cap_q[q] <= req_wdata_in[HSQ_CNT_W-1:0];
    end
  end

  // ==========================================================
  // Answer buffer
  hsq_skid #(
    .W(33)
  ) u_skid (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .in_valid_in(req_valid_in),
    .in_ready_out(req_ready_out),
    .in_data_in({err, rdata}),
    .out_valid_out(resp_valid_out),
    .out_ready_in(resp_ready_in),
    .out_data_out({resp_err_out, resp_data_out})
  );
endmodule
`default_nettype wire

// [hsq_pkg.sv]
`default_nettype none
// ==========================================================
// Shared constants for the queue bank
package hsq_pkg;
  // Bank shape
  localparam int HSQ_NQ = 4;
  localparam int HSQ_DEPTH = 64;
  localparam int HSQ_PTR_W = 6;
  localparam int HSQ_CNT_W = 7;
  localparam int HSQ_MEM_W = 8;
  // Register addresses (word-register numbering)
  localparam logic [15:0] HSQ_ADDR_HALF = 16'hb798;
  localparam logic [15:0] HSQ_ADDR_UWORD = 16'hb7a2;
  localparam logic [15:0] HSQ_ADDR_SWORD = 16'hb7ac;
  localparam logic [15:0] HSQ_ADDR_FLOAT = 16'hb7b6;
  localparam logic [15:0] HSQ_ADDR_CAP = 16'hbb1c;
  localparam logic [15:0] HSQ_ADDR_OCC = 16'hbb26;
  localparam logic [15:0] HSQ_ADDR_FLUSH = 16'hbb3a;
  localparam logic [15:0] HSQ_STRIDE = 16'h0002;
  localparam logic [15:0] HSQ_SPAN = 16'h0008;
  // Bytes moved per access
  localparam logic [2:0] HSQ_HALF_BYTES = 3'h2;
  localparam logic [2:0] HSQ_WORD_BYTES = 3'h4;
  // Reset values
  localparam logic [HSQ_CNT_W-1:0] HSQ_CAP_RST = 7'h00;
  localparam logic [HSQ_CNT_W-1:0] HSQ_CNT_RST = 7'h00;
  localparam logic [HSQ_PTR_W-1:0] HSQ_PTR_RST = 6'h00;
  // Register kinds
  typedef enum logic [2:0] {
    HSQ_K_NONE = 3'h0,
    HSQ_K_HALF = 3'h1,
    HSQ_K_UWORD = 3'h2,
    HSQ_K_SWORD = 3'h3,
    HSQ_K_FLOAT = 3'h4,
    HSQ_K_CAP = 3'h5,
    HSQ_K_OCC = 3'h6,
    HSQ_K_FLUSH = 3'h7
  } hsq_kind_t;
endpackage
`default_nettype wire

// [hsq_skid.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Two-entry answer buffer
module hsq_skid #(
  parameter int W = 33
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  // Filling side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  // Draining side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);
  logic [W-1:0] slot_q [0:1];
  logic wp_q;
  logic rp_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;

  // Handshake terms
  assign in_ready_out = (cnt_q != 2'h2);
  assign out_valid_out = (cnt_q != 2'h0);
  assign out_data_out = slot_q[rp_q];
  assign push = ce_in & in_valid_in & in_ready_out;
  assign pop = ce_in & out_valid_out & out_ready_in;

  // Storage slots
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      slot_q[0] <= '0;
      slot_q[1] <= '0;
    end else if (push) begin
      slot_q[wp_q] <= in_data_in;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 2'h1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [hsq_props.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port checker for the queue bank
module hsq_props (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  // Request
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [15:0] req_addr_in,
  input wire logic [31:0] req_wdata_in,
  input wire logic req_ready_out,
  // Answer
  input wire logic resp_valid_out,
  input wire logic resp_ready_in,
  input wire logic [31:0] resp_data_out,
  input wire logic resp_err_out
);
  import hsq_pkg::*;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  // Request taken while no answer waits
  wire logic tk = req_valid_in && req_ready_out && ce_in && !resp_valid_out;
  // Answer timing and buffer
  a_answer_next: assert property (tk |=> resp_valid_out)
    else $error("no answer");
  a_answer_holds: assert property (resp_valid_out && !(resp_ready_in && ce_in)
    |=> resp_valid_out && $stable(resp_data_out)) else $error("answer dropped");
  a_ready_room: assert property (!resp_valid_out |-> req_ready_out)
    else $error("ready low while empty");
  // Refusals
  a_err_nodata: assert property (resp_valid_out && resp_err_out |-> resp_data_out == 32'h0)
    else $error("error with data");
  a_unmapped_err: assert property (tk && req_addr_in == 16'hb799 |=> resp_err_out)
    else $error("unmapped accepted");
  a_flush_read: assert property (tk && !req_write_in && req_addr_in == HSQ_ADDR_FLUSH |=> resp_err_out)
    else $error("flush read accepted");
  a_occ_readonly: assert property (tk && req_write_in && req_addr_in == HSQ_ADDR_OCC |=> resp_err_out)
    else $error("occupancy write accepted");
  a_cap_limit: assert property (tk && req_write_in && req_addr_in == HSQ_ADDR_CAP
    |=> resp_err_out == ($past(req_wdata_in) > 32'h40)) else $error("capacity limit wrong");
endmodule
bind hsq_fifo_bank hsq_props i_props (.clock_in(clock_in), .resetn_in(resetn_in), .ce_in(ce_in),
  .req_valid_in(req_valid_in), .req_write_in(req_write_in), .req_addr_in(req_addr_in),
  .req_wdata_in(req_wdata_in), .req_ready_out(req_ready_out), .resp_valid_out(resp_valid_out),
  .resp_ready_in(resp_ready_in), .resp_data_out(resp_data_out), .resp_err_out(resp_err_out));
`default_nettype wire

// [hsq_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Host answer sink: prompt, slow or stalled
module hsq_host_model (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Pace: 0 prompt, 1 every other cycle, 2 stalled
  input wire logic [1:0] pace_in,
  // Answer handshake
  output logic resp_ready_out
);
  logic tog_q;
  // Alternating phase for slow pace
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tog_q <= 1'h0;
    end else begin
      tog_q <= ~tog_q;
    end
  end
  // Ready level from pace
  assign resp_ready_out = (pace_in == 2'h0) || (pace_in == 2'h1 && tog_q);
endmodule
`default_nettype wire

// [hsq_fifo_bank_tb.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Self-checking bench for the queue bank
module hsq_fifo_bank_tb;
  import hsq_pkg::*;
  logic clk, rstn, ce, rq_v, rq_w, rq_r, rs_v, rs_r, rs_e;
  logic [15:0] rq_a;
  logic [31:0] rq_d, rs_d;
  logic [1:0] pace;
  int bad_count, checked, cycles;
  hsq_fifo_bank i_dut (.clock_in(clk), .resetn_in(rstn), .ce_in(ce), .req_valid_in(rq_v),
    .req_write_in(rq_w), .req_addr_in(rq_a), .req_wdata_in(rq_d), .req_ready_out(rq_r),
    .resp_valid_out(rs_v), .resp_ready_in(rs_r), .resp_data_out(rs_d), .resp_err_out(rs_e));
  hsq_host_model i_host (.clock_in(clk), .resetn_in(rstn), .pace_in(pace), .resp_ready_out(rs_r));
  // Clock and hang guard
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (bad_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask
  // One access, held until taken, answer judged when handed over
  task automatic op(input logic w, input logic [15:0] a, input logic [31:0] d,
                    input logic [31:0] x, input logic xe);
    rq_v = 1'h1;
    rq_w = w;
    rq_a = a;
    rq_d = d;
    while (!rq_r) @(negedge clk);
    @(negedge clk);
    rq_v = 1'h0;
    while (!(rs_v && rs_r)) @(negedge clk);
    chk($sformatf("data %0d", a), x, rs_d);
    chk($sformatf("err %0d", a), {31'h0, xe}, {31'h0, rs_e});
    @(negedge clk);
  endtask
  // Empty queues after reset
  task automatic t_reset();
    for (int q = 0; q < HSQ_NQ; q++) begin
      op(1'h0, HSQ_ADDR_OCC + HSQ_STRIDE * 16'(q), 32'h0, 32'h0, 1'h0);
      op(1'h0, HSQ_ADDR_CAP + HSQ_STRIDE * 16'(q), 32'h0, 32'h0, 1'h0);
    end
  endtask
  // Mixed port types on queue one, slow host
  task automatic t_mixed();
    pace = 2'h1;
    op(1'h1, HSQ_ADDR_CAP + 16'h2, 32'h8, 32'h0, 1'h0);
    op(1'h1, HSQ_ADDR_FLOAT + 16'h2, 32'h11223344, 32'h0, 1'h0);
    op(1'h0, 16'd47912, 32'h0, 32'h4, 1'h0);
    op(1'h0, HSQ_ADDR_HALF + 16'h2, 32'h0, 32'h1122, 1'h0);
    op(1'h0, HSQ_ADDR_OCC + 16'h2, 32'h0, 32'h2, 1'h0);
    op(1'h0, HSQ_ADDR_SWORD + 16'h2, 32'h0, 32'h0, 1'h1);
    op(1'h0, HSQ_ADDR_HALF + 16'h2, 32'h0, 32'h3344, 1'h0);
    op(1'h1, HSQ_ADDR_UWORD + 16'h2, 32'haabbccdd, 32'h0, 1'h0);
    op(1'h0, 16'd47032, 32'h0, 32'haabbccdd, 1'h0);
    pace = 2'h0;
  endtask
  // Capacity, overfill, flush and refusals on queue zero
  task automatic t_limits();
    op(1'h1, HSQ_ADDR_CAP, 32'h8, 32'h0, 1'h0);
    op(1'h1, HSQ_ADDR_UWORD, 32'ha0a1a2a3, 32'h0, 1'h0);
    op(1'h1, HSQ_ADDR_SWORD, 32'hb0b1b2b3, 32'h0, 1'h0);
    op(1'h1, HSQ_ADDR_HALF, 32'hc0c1, 32'h0, 1'h1);
    op(1'h0, HSQ_ADDR_OCC, 32'h0, 32'h8, 1'h0);
    op(1'h0, HSQ_ADDR_FLOAT, 32'h0, 32'ha0a1a2a3, 1'h0);
    op(1'h1, HSQ_ADDR_FLUSH, 32'h5a, 32'h0, 1'h0);
    op(1'h0, HSQ_ADDR_OCC, 32'h0, 32'h0, 1'h0);
    op(1'h0, HSQ_ADDR_FLUSH, 32'h0, 32'h0, 1'h1);
    op(1'h1, HSQ_ADDR_OCC, 32'h1, 32'h0, 1'h1);
    op(1'h1, HSQ_ADDR_CAP, 32'h41, 32'h0, 1'h1);
    op(1'h1, HSQ_ADDR_CAP, 32'h40, 32'h0, 1'h0);
    op(1'h0, HSQ_ADDR_HALF + 16'h1, 32'h0, 32'h0, 1'h1);
  endtask
  // Two answers held by a stalled host, then drained in order
  task automatic t_burst();
    pace = 2'h2;
    rq_v = 1'h1;
    rq_w = 1'h0;
    rq_a = HSQ_ADDR_CAP;
    @(negedge clk);
    rq_a = HSQ_ADDR_HALF + 16'h1;
    @(negedge clk);
    rq_v = 1'h0;
    chk("ready full", 32'h0, {31'h0, rq_r});
    pace = 2'h0;
    chk("first data", 32'h40, rs_d);
    @(negedge clk);
    chk("second err", 32'h1, {31'h0, rs_e});
    @(negedge clk);
    chk("drained", 32'h0, {31'h0, rs_v});
  endtask
  // Enable low freezes the bank, then a mid-run reset empties queue two
  task automatic t_freeze();
    ce = 1'h0;
    rq_v = 1'h1;
    rq_w = 1'h1;
    rq_a = HSQ_ADDR_CAP + 16'h4;
    rq_d = 32'h10;
    repeat (3) @(negedge clk);
    chk("frozen ready", 32'h1, {31'h0, rq_r});
    chk("frozen answer", 32'h0, {31'h0, rs_v});
    rq_v = 1'h0;
    ce = 1'h1;
    @(negedge clk);
    chk("no late answer", 32'h0, {31'h0, rs_v});
    op(1'h0, HSQ_ADDR_CAP + 16'h4, 32'h0, 32'h0, 1'h0);
    op(1'h1, HSQ_ADDR_CAP + 16'h4, 32'h10, 32'h0, 1'h0);
    op(1'h1, HSQ_ADDR_SWORD + 16'h4, 32'h01020304, 32'h0, 1'h0);
    op(1'h1, HSQ_ADDR_HALF + 16'h4, 32'h0506, 32'h0, 1'h0);
    op(1'h0, HSQ_ADDR_OCC + 16'h4, 32'h0, 32'h6, 1'h0);
    op(1'h0, HSQ_ADDR_UWORD + 16'h4, 32'h0, 32'h01020304, 1'h0);
    rstn = 1'h0;
    repeat (2) @(negedge clk);
    rstn = 1'h1;
    chk("reset idle", 32'h0, {31'h0, rs_v});
    op(1'h0, HSQ_ADDR_OCC + 16'h4, 32'h0, 32'h0, 1'h0);
    op(1'h0, HSQ_ADDR_CAP + 16'h4, 32'h0, 32'h0, 1'h0);
    op(1'h0, HSQ_ADDR_HALF + 16'h4, 32'h0, 32'h0, 1'h1);
  endtask
  initial begin
    clk = 1'h0;
    rstn = 1'h0;
    ce = 1'h1;
    rq_v = 1'h0;
    rq_w = 1'h0;
    rq_a = 16'h0;
    rq_d = 32'h0;
    pace = 2'h0;
    repeat (8) @(negedge clk);
    rstn = 1'h1;
    t_reset();
    t_mixed();
    t_limits();
    t_burst();
    t_freeze();
    print_verdict();
  end
endmodule
`default_nettype wire
